// *** core/pri_pkg.sv ***
package pri_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [15:0] ADR_RX_PATH_CTL  = 16'h1183;
   localparam logic [15:0] ADR_TX_OH_CTL    = 16'h1983;
   localparam logic [15:0] ADR_STATUS_BYTE  = 16'h199F;
   localparam logic [15:0] ADR_REI_STATUS   = 16'h1985;
   localparam logic [7:0]  RST_RX_PATH_CTL  = 8'h00;
   localparam logic [7:0]  RST_TX_OH_CTL    = 8'h00;
   localparam logic [7:0]  RST_STATUS_BYTE  = 8'h00;
   localparam logic [7:0]  RX_CTL_WMASK     = 8'h0F;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int STYLE_BIT   = 0;
   localparam int SEL_LO      = 5;
   localparam int SEL_HI      = 6;
   localparam int SWV_LO      = 4;
   localparam int SWV_HI      = 7;
   localparam int ST_FIFO_BIT = 4;
   localparam int ST_BUSY_BIT = 5;
   // ----------------------------------------------------------------
   // source select codes and value limits
   // ----------------------------------------------------------------
   localparam logic [1:0] SEL_AUTO = 2'h0;
   localparam logic [1:0] SEL_SW   = 2'h1;
   localparam logic [1:0] SEL_EXT  = 2'h2;
   localparam logic [3:0] REI_ZERO = 4'h0;
   localparam logic [3:0] REI_ONE  = 4'h1;
   localparam logic [3:0] REI_MAX  = 4'h8;
   // ----------------------------------------------------------------
   // serial port timing in port clock periods, fifo depth and nibble width
   // ----------------------------------------------------------------
   localparam logic [5:0] WAIT_PERIODS = 6'h1C;
   localparam logic [5:0] BIT_FIRST    = WAIT_PERIODS + 6'h01;
   localparam logic [5:0] BIT_LAST     = WAIT_PERIODS + 6'h04;
   localparam int         FIFO_DEPTH   = 8;
   localparam int         REI_W        = 4;
   // capture engine states
   typedef enum logic [1:0] {
      CAP_IDLE  = 2'b00,
      CAP_ARM   = 2'b01,
      CAP_COUNT = 2'b10
   } pri_cap_t;
endpackage : pri_pkg

// *** core/pri_top.sv ***
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// How it works
// - auto mode sends REI whenever the receive side reports any B3 error
// - select 00 fills G1 bits 1-4 from the receive B3 result
// - receive control bit 0 picks count style or per-SPE flag style
// - count style sends errored B3 bit count, 0 to 8
// - flag style sends 1 for an errored SPE, else 0
// - select 01 copies status byte bits 7:4 into G1 bits 1-4
// - select 10 takes REI bits from the serial overhead input
// - each serial bit is latched on the rise after its driving fall

// ------------------------------------------------------------------
// small fifo
// ------------------------------------------------------------------
module pri_fifo #(
   parameter int W = 4,
   parameter int D = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0]         wp;
      logic [AW:0]         rp;
   } pri_fifo_st_t;
   pri_fifo_st_t s_q, s_d;
   logic full, empty;

   // full and empty from pointer wrap bits
   assign empty     = (s_q.wp == s_q.rp);
   assign full      = (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]) && (s_q.wp[AW] != s_q.rp[AW]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = s_q.mem[s_q.rp[AW-1:0]];

   // pointer and storage update
   always_comb begin
      s_d = s_q;
      if (in_valid && !full) begin
         s_d.mem[s_q.wp[AW-1:0]] = in_data;
         s_d.wp = s_q.wp + 1'b1;
      end
      if (out_ready && !empty) begin
         s_d.rp = s_q.rp + 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : pri_fifo

// ------------------------------------------------------------------
// REI-P source selection and insertion
// ------------------------------------------------------------------
module pri_top (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // register port
   input  wire logic [15:0] REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic [7:0]       REG_RDATA,
   // receive path B3 result
   input  wire logic        B3_RESULT_VALID,
   input  wire logic [3:0]  B3_ERR_BITS,
   // transmit SPE timing
   input  wire logic        SPE_FRAME_START,
   input  wire logic        G1_SLOT,
   output logic [3:0]       REI_OUT,
   output logic             REI_OUT_VALID,
   // serial overhead port
   input  wire logic        OVERHEAD_PORT_CLOCK,
   input  wire logic        EXT_OVERHEAD_SERIAL_IN,
   output logic             OVERHEAD_PORT_WINDOW,
   output logic             OVERHEAD_FRAME_MARK
);
   typedef struct packed {
      logic [7:0]       rx_ctl;
      logic [7:0]       tx_ctl;
      logic [7:0]       g1val;
      logic [7:0]       rdata;
      logic [3:0]       b3_rei;
      logic [3:0]       ext_rei;
      logic [3:0]       rei_out;
      logic             rei_vld;
      logic [2:0]       ck_sh;
      logic [2:0]       dn_sh;
      logic             ck_lvl;
      logic             dn_lvl;
      logic             pend;
      pri_pkg::pri_cap_t cap;
      logic [5:0]       cnt;
      logic [3:0]       shreg;
      logic             window;
      logic             mark;
      logic             push;
   } pri_st_t;
   pri_st_t s_q, s_d;

   logic [1:0] sel;
   logic       style;
   logic       rise, fall;
   logic       f_ready, f_valid;
   logic [3:0] f_data;
   logic       f_pop;

   // register field decode
   assign sel   = s_q.tx_ctl[pri_pkg::SEL_HI:pri_pkg::SEL_LO];
   assign style = s_q.rx_ctl[pri_pkg::STYLE_BIT];
   // port clock edges from the agreed level
   assign rise  = (s_q.ck_sh[1] == s_q.ck_sh[2]) && s_q.ck_sh[2] && !s_q.ck_lvl;
   assign fall  = (s_q.ck_sh[1] == s_q.ck_sh[2]) && !s_q.ck_sh[2] && s_q.ck_lvl;
   assign f_pop = G1_SLOT && (sel == pri_pkg::SEL_EXT);

   // outputs
   assign REG_RDATA            = s_q.rdata;
   assign REI_OUT              = s_q.rei_out;
   assign REI_OUT_VALID        = s_q.rei_vld;
   assign OVERHEAD_PORT_WINDOW = s_q.window;
   assign OVERHEAD_FRAME_MARK  = s_q.mark;

   // received nibble buffer
   pri_fifo #(.W(pri_pkg::REI_W), .D(pri_pkg::FIFO_DEPTH)) u_fifo (
      .clk       (CLK),
      .rst       (RST),
      .in_valid  (s_q.push),
      .in_ready  (f_ready),
      .in_data   (s_q.shreg),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (f_data)
   );

   // next state
   always_comb begin
      s_d      = s_q;
      s_d.push = 1'b0;
      s_d.rei_vld = 1'b0;
      // registers written by software
      if (REG_WR) begin
         unique case (REG_ADDR)
            pri_pkg::ADR_RX_PATH_CTL: s_d.rx_ctl = REG_WDATA & pri_pkg::RX_CTL_WMASK;
            pri_pkg::ADR_TX_OH_CTL:   s_d.tx_ctl = REG_WDATA;
            pri_pkg::ADR_STATUS_BYTE: s_d.g1val  = REG_WDATA;
            default: ;
         endcase
      end
      // read data, one cycle after the strobe
      s_d.rdata = 8'h00;
      if (REG_RD) begin
         unique case (REG_ADDR)
            pri_pkg::ADR_RX_PATH_CTL: s_d.rdata = s_q.rx_ctl;
            pri_pkg::ADR_TX_OH_CTL:   s_d.rdata = s_q.tx_ctl;
            pri_pkg::ADR_STATUS_BYTE: s_d.rdata = s_q.g1val;
            pri_pkg::ADR_REI_STATUS: begin
               s_d.rdata[3:0] = s_q.rei_out;
               s_d.rdata[pri_pkg::ST_FIFO_BIT] = f_valid;
               s_d.rdata[pri_pkg::ST_BUSY_BIT] = (s_q.cap != pri_pkg::CAP_IDLE);
            end
            default: s_d.rdata = 8'h00;
         endcase
      end
      if (B3_RESULT_VALID) begin
         if (style) begin
            s_d.b3_rei = (B3_ERR_BITS != pri_pkg::REI_ZERO) ? pri_pkg::REI_ONE
                                                            : pri_pkg::REI_ZERO;
         end else begin
            s_d.b3_rei = (B3_ERR_BITS > pri_pkg::REI_MAX) ? pri_pkg::REI_MAX
                                                          : B3_ERR_BITS;
         end
      end
      // port clock and serial input synchronisers
      s_d.ck_sh = {s_q.ck_sh[1:0], OVERHEAD_PORT_CLOCK};
      s_d.dn_sh = {s_q.dn_sh[1:0], EXT_OVERHEAD_SERIAL_IN};
      if (s_q.ck_sh[1] == s_q.ck_sh[2]) begin
         s_d.ck_lvl = s_q.ck_sh[2];
      end
      if (s_q.dn_sh[1] == s_q.dn_sh[2]) begin
         s_d.dn_lvl = s_q.dn_sh[2];
      end
      // frame start request, set wins over the take
      s_d.pend = s_q.pend | SPE_FRAME_START;
      unique case (s_q.cap)
         pri_pkg::CAP_IDLE: begin
            if (s_q.pend && f_ready && sel == pri_pkg::SEL_EXT) begin
               s_d.pend = SPE_FRAME_START;
               s_d.cap  = pri_pkg::CAP_ARM;
            end
         end
         pri_pkg::CAP_ARM: begin
            if (fall) begin
               s_d.window = 1'b1;
               s_d.mark   = 1'b1;
               s_d.cnt    = 6'h00;
               s_d.cap    = pri_pkg::CAP_COUNT;
            end
         end
         pri_pkg::CAP_COUNT: begin
            if (fall && s_q.cnt != 6'h00) begin
               s_d.mark = 1'b0;
            end
            if (rise) begin
               s_d.cnt = s_q.cnt + 6'h01;
               if (s_q.cnt >= pri_pkg::BIT_FIRST) begin
                  s_d.shreg = {s_q.shreg[2:0], s_q.dn_lvl};
               end
               if (s_q.cnt == pri_pkg::BIT_LAST) begin
                  s_d.push   = 1'b1;
                  s_d.window = 1'b0;
                  s_d.cap    = pri_pkg::CAP_IDLE;
               end
            end
         end
         default: s_d.cap = pri_pkg::CAP_IDLE;
      endcase
      if (G1_SLOT) begin
         s_d.rei_vld = 1'b1;
         unique case (sel)
            pri_pkg::SEL_SW:  s_d.rei_out = s_q.g1val[pri_pkg::SWV_HI:pri_pkg::SWV_LO];
            pri_pkg::SEL_EXT: s_d.rei_out = f_valid ? f_data : s_q.ext_rei;
            default:          s_d.rei_out = s_q.b3_rei;
         endcase
         if (f_pop && f_valid) begin
            s_d.ext_rei = f_data;
         end
      end
   end

   // state register
   always_ff @(posedge CLK) begin
      if (RST) begin
         s_q        <= '0;
         s_q.rx_ctl <= pri_pkg::RST_RX_PATH_CTL;
         s_q.tx_ctl <= pri_pkg::RST_TX_OH_CTL;
         s_q.g1val  <= pri_pkg::RST_STATUS_BYTE;
         s_q.cap    <= pri_pkg::CAP_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   AST_AUTO_ANY_ERR: assert property (
      G1_SLOT && sel == pri_pkg::SEL_AUTO && s_q.b3_rei != 4'h0 |=> REI_OUT != 4'h0)
      else $error("auto REI lost an error");
   AST_AUTO_SRC: assert property (
      G1_SLOT && sel == pri_pkg::SEL_AUTO |=> REI_OUT == $past(s_q.b3_rei) && REI_OUT_VALID)
      else $error("auto REI source wrong");
   AST_FLAG_ZERO: assert property (
      B3_RESULT_VALID && style && B3_ERR_BITS == 4'h0 |=> s_q.b3_rei == 4'h0)
      else $error("flag style gave nonzero for clean SPE");
   AST_COUNT: assert property (
      B3_RESULT_VALID && !style && B3_ERR_BITS <= 4'h8 |=> s_q.b3_rei == $past(B3_ERR_BITS))
      else $error("count style value wrong");
   AST_FLAG_ONE: assert property (
      B3_RESULT_VALID && style && B3_ERR_BITS != 4'h0 |=> s_q.b3_rei == 4'h1)
      else $error("flag style value wrong");
   AST_SW_SRC: assert property (
      G1_SLOT && sel == pri_pkg::SEL_SW |=> REI_OUT == $past(s_q.g1val[7:4]))
      else $error("software REI source wrong");
   AST_EXT_SRC: assert property (
      G1_SLOT && sel == pri_pkg::SEL_EXT && f_valid |=> REI_OUT == $past(f_data))
      else $error("serial REI source wrong");
   AST_LATCH: assert property (
      s_q.cap == pri_pkg::CAP_COUNT && rise && s_q.cnt >= pri_pkg::BIT_FIRST
      |=> s_q.shreg[0] == $past(s_q.dn_lvl))
      else $error("serial bit not latched on rise");
   AST_NO_EARLY: assert property (
      s_q.cap == pri_pkg::CAP_COUNT && rise && s_q.cnt < pri_pkg::BIT_FIRST
      |=> s_q.shreg == $past(s_q.shreg))
      else $error("serial bit latched before its driving fall");
   AST_PUSH_WIN: assert property (
      s_q.push |-> !OVERHEAD_PORT_WINDOW && $past(OVERHEAD_PORT_WINDOW))
      else $error("nibble pushed outside window");

   COV_AUTO: cover property (G1_SLOT && sel == pri_pkg::SEL_AUTO && s_q.b3_rei == 4'h8);
   COV_SW:   cover property (G1_SLOT && sel == pri_pkg::SEL_SW);
   COV_EXT:  cover property (s_q.push ##[1:1000] (G1_SLOT && sel == pri_pkg::SEL_EXT));
endmodule : pri_top

// *** testbench/pri_far_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------------
// far-end overhead insertion logic
// ------------------------------------------------------------------
module pri_far_model (
   // port side
   input  wire logic       pclk,
   input  wire logic       window,
   input  wire logic       mark,
   // nibble to send, msb first
   input  wire logic [3:0] nibble,
   output logic            sdo
);
   // watch for frame marks, then shift the nibble out
   initial begin
      sdo = 1'b0;
      forever begin
         @(posedge pclk);
         if (window && mark) begin
            repeat (28) @(posedge pclk);
            for (int i = 3; i >= 0; i--) begin
               @(negedge pclk);
               sdo = nibble[i];
            end
            // released line shows the inverse, never the last bit
            @(negedge pclk);
            sdo = ~sdo;
         end
      end
   end
endmodule : pri_far_model

// *** testbench/tb_pri_top.sv ***
`timescale 1ns/1ps
module tb_pri_top;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] rxc;
      logic [7:0] swv;
      logic [3:0] b3;
      logic [3:0] e;
   } pri_row_t;
   logic        CLK, RST, REG_WR, REG_RD, B3_RESULT_VALID, SPE_FRAME_START, G1_SLOT;
   logic        OVERHEAD_PORT_CLOCK, EXT_OVERHEAD_SERIAL_IN, REI_OUT_VALID;
   logic        OVERHEAD_PORT_WINDOW, OVERHEAD_FRAME_MARK;
   logic [15:0] REG_ADDR;
   logic [7:0]  REG_WDATA, REG_RDATA;
   logic [3:0]  B3_ERR_BITS, REI_OUT, nib;
   int          n_mismatch  = 0;
   int          check_count = 0;
   pri_row_t    rows [10] = '{
      '{8'h00, 8'h00, 8'h00, 4'h0, 4'h0}, '{8'h00, 8'h00, 8'h00, 4'h3, 4'h3},
      '{8'h00, 8'h00, 8'h00, 4'h8, 4'h8}, '{8'h00, 8'h01, 8'h00, 4'h5, 4'h1},
      '{8'h00, 8'h01, 8'h00, 4'h8, 4'h1}, '{8'h00, 8'h01, 8'h00, 4'h0, 4'h0},
      '{8'h60, 8'h00, 8'h00, 4'h2, 4'h2}, '{8'h20, 8'h00, 8'h80, 4'h3, 4'h8},
      '{8'h20, 8'h00, 8'h5F, 4'h3, 4'h5}, '{8'h20, 8'h00, 8'h0F, 4'h7, 4'h0}};
   // clocks: core 10 ns, port 160 ns
   always #5 CLK = ~CLK;
   always #80 OVERHEAD_PORT_CLOCK = ~OVERHEAD_PORT_CLOCK;
   // ---------------------------------------------------------------
   // design and far end
   // ---------------------------------------------------------------
   pri_top pri_top_i (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .B3_RESULT_VALID(B3_RESULT_VALID), .B3_ERR_BITS(B3_ERR_BITS),
      .SPE_FRAME_START(SPE_FRAME_START), .G1_SLOT(G1_SLOT), .REI_OUT(REI_OUT),
      .REI_OUT_VALID(REI_OUT_VALID), .OVERHEAD_PORT_CLOCK(OVERHEAD_PORT_CLOCK),
      .EXT_OVERHEAD_SERIAL_IN(EXT_OVERHEAD_SERIAL_IN),
      .OVERHEAD_PORT_WINDOW(OVERHEAD_PORT_WINDOW), .OVERHEAD_FRAME_MARK(OVERHEAD_FRAME_MARK));
   pri_far_model pri_far_model_i (.pclk(OVERHEAD_PORT_CLOCK), .window(OVERHEAD_PORT_WINDOW),
      .mark(OVERHEAD_FRAME_MARK), .nibble(nib), .sdo(EXT_OVERHEAD_SERIAL_IN));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge CLK);
      REG_ADDR  <= a;
      REG_WDATA <= d;
      REG_WR    <= 1'b1;
      @(posedge CLK);
      REG_WR    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_RD   <= 1'b1;
      @(posedge CLK);
      REG_RD   <= 1'b0;
      #1;
      chk(REG_RDATA, exp, "read");
   endtask : rd
   task automatic b3(input logic [3:0] v);
      @(posedge CLK);
      B3_RESULT_VALID <= 1'b1;
      B3_ERR_BITS     <= v;
      @(posedge CLK);
      B3_RESULT_VALID <= 1'b0;
   endtask : b3
   task automatic slot(input logic [3:0] e);
      @(posedge CLK);
      G1_SLOT <= 1'b1;
      @(posedge CLK);
      G1_SLOT <= 1'b0;
      #1;
      chk({7'h00, REI_OUT_VALID}, 8'h01, "valid");
      chk({4'h0, REI_OUT}, {4'h0, e}, "rei");
   endtask : slot
   task automatic wait_win(input logic lvl);
      int n;
      n = 0;
      while (OVERHEAD_PORT_WINDOW !== lvl && n < 2000) begin
         @(posedge CLK);
         #1;
         n++;
      end
      if (n >= 2000) begin
         n_mismatch++;
         $display("MISMATCH t=%0t window wait", $time);
      end
   endtask : wait_win
   task automatic frame(input logic [3:0] v);
      nib = v;
      @(posedge CLK);
      SPE_FRAME_START <= 1'b1;
      @(posedge CLK);
      SPE_FRAME_START <= 1'b0;
      wait_win(1'b1);
      chk({7'h00, OVERHEAD_FRAME_MARK}, 8'h01, "mark");
      wait_win(1'b0);
   endtask : frame
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {CLK, REG_WR, REG_RD, B3_RESULT_VALID, SPE_FRAME_START, G1_SLOT} = '0;
      {OVERHEAD_PORT_CLOCK, REG_ADDR, REG_WDATA, B3_ERR_BITS, nib} = '0;
      RST = 1'b1;
      repeat (6) @(posedge CLK);
      RST <= 1'b0;
      rd(pri_pkg::ADR_TX_OH_CTL, pri_pkg::RST_TX_OH_CTL);
      rd(pri_pkg::ADR_RX_PATH_CTL, pri_pkg::RST_RX_PATH_CTL);
      rd(pri_pkg::ADR_STATUS_BYTE, pri_pkg::RST_STATUS_BYTE);
      chk({4'h0, REI_OUT}, 8'h00, "rei reset");
      $display("test reset done");
      // table of source and style cases
      foreach (rows[i]) begin
         wr(pri_pkg::ADR_TX_OH_CTL, rows[i].ctl);
         wr(pri_pkg::ADR_RX_PATH_CTL, rows[i].rxc);
         wr(pri_pkg::ADR_STATUS_BYTE, rows[i].swv);
         b3(rows[i].b3);
         slot(rows[i].e);
      end
      $display("test table done");
      // read-only upper bits, unmapped place, one-cycle read data
      wr(pri_pkg::ADR_RX_PATH_CTL, 8'hFF);
      rd(pri_pkg::ADR_RX_PATH_CTL, 8'h0F);
      @(posedge CLK);
      #1;
      chk(REG_RDATA, 8'h00, "rdata hold");
      wr(16'h1984, 8'hAA);
      rd(16'h1984, 8'h00);
      $display("test registers done");
      // serial source: fill fifo while slots stall
      wr(pri_pkg::ADR_TX_OH_CTL, 8'h40);
      for (int i = 1; i <= 8; i++) frame(4'(i));
      nib = 4'hC;
      @(posedge CLK);
      SPE_FRAME_START <= 1'b1;
      @(posedge CLK);
      SPE_FRAME_START <= 1'b0;
      repeat (64) @(posedge CLK);
      #1;
      chk({7'h00, OVERHEAD_PORT_WINDOW}, 8'h00, "full refusal");
      // drain in order, empty repeats the last nibble
      for (int i = 1; i <= 8; i++) slot(4'(i));
      slot(4'h8);
      wait_win(1'b1);
      wait_win(1'b0);
      slot(4'hC);
      rd(pri_pkg::ADR_REI_STATUS, 8'h0C);
      $display("test serial done");
      // mid-run reset returns control and output to reset values
      @(posedge CLK);
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      rd(pri_pkg::ADR_TX_OH_CTL, pri_pkg::RST_TX_OH_CTL);
      chk({4'h0, REI_OUT}, 8'h00, "rei mid reset");
      $display("test mid reset done");
      report_and_stop();
   end
   // watchdog well past the expected run
   initial begin
      repeat (30000) @(posedge CLK);
      n_mismatch++;
      report_and_stop();
   end
endmodule : tb_pri_top
